/* File: hw/mfg_defines.svh */
// Purpose: constants for the multifunction pin trigger block
// Assumes: APB register map, 32-bit data
// Notes: byte offsets
`ifndef MFG_DEFINES_SVH
`define MFG_DEFINES_SVH
`define MFG_OFF_CFG 12'h000
`define MFG_OFF_SWCMD 12'h004
`define MFG_OFF_STATUS 12'h008
`define MFG_OFF_ACTION 12'h00c
`define MFG_OFF_NVM 12'h010
`define MFG_CFG_RESET 22'h00_0000
`define MFG_FN_NONE 4'h0
`define MFG_FN_FAULT 4'h2
`define MFG_FN_CURRENT_OUTPUT 4'h3
`define MFG_FN_VOLTAGE_OUTPUT 4'h4
`define MFG_FN_PROTECT 4'h5
`define MFG_FN_CLEAR 4'h7
`define MFG_FN_SYNC 4'h8
`define MFG_FN_RESET 4'hb
`endif

/* File: hw/mfg_pkg.sv */
// Purpose: types for the multifunction pin trigger block
// Assumes: nothing
// Notes: config layout mirrors the cfg register
package mfg_pkg;
  typedef struct packed {
    logic [3:0] voltage_output_pdn_sel;
    logic [3:0] sync_update;
    logic [3:0] out_fn;
    logic [3:0] in_fn;
    logic [3:0] trigger_channel_select;
    logic pin_output_enable;
    logic pin_input_enable;
  } mfg_cfg_t;
  typedef struct packed {
    logic fault_dump;
    logic protect;
    logic output_clear_action;
    logic synchronous_load_action;
    logic dev_reset;
    logic [3:0] current_output_pd;
    logic [3:0] current_output_pu;
    logic [3:0] voltage_output_pd;
    logic [3:0] voltage_output_pu;
  } mfg_act_t;
  typedef enum {MFG_BOOT, MFG_LEVEL, MFG_RUN} mfg_phase_t;
endpackage

/* File: hw/mfg_sync.sv */
// Purpose: two-stage pin synchroniser with edge pulses
// Assumes: pin is asynchronous to CLK
// Notes: first stage read only by second
`timescale 1ns/1ps
`default_nettype none
module mfg_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } mfg_sync_st_t;
  mfg_sync_st_t st, next_st;
  always_comb begin
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= 3'b111;
    end else begin
      st <= next_st;
    end
  end
  assign level = st.s2;
  assign rise = st.s2 & ~st.s3;
  assign fall = ~st.s2 & st.s3;
endmodule
`default_nettype wire

/* File: hw/mfg_top.sv */
// Purpose: multifunction pin logic of a quad DAC, APB registers
// Assumes: 250 MHz CLK, SYS_RST async active high
// Notes: actions leave as one-cycle pulses
// What this block does
// - input enable routes pin into decoder
// - output enable drives selected status out, only while input enable is off
// - channel functions follow channel select field
// - after boot, act on defined edges only
// - sample pin level once after power-up
// - reset function code selects no operation
// - software bit ignored while pin mapped to that same function
// - pin triggers obey software preconditions
// - reset mapping survives only when nonvolatile
// - settings load from nonvolatile store
// - codes 2,5: falling fault dump, protect
// - codes 3,4: falling down, rising up
// - code 7: falling edge clears all
// - output pin shows selected status
// - sync load needs sync enable, and select when triggered by the pin
//
// The APB interface to the registers and the register addresses were decided locally.
`include "mfg_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module mfg_top (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic PIN_IN,
  output logic PIN_OUT,
  output logic PIN_OE,
  input wire logic NVM_VALID,
  input wire logic [23:0] NVM_CFG,
  input wire logic [10:0] STATUS_IN,
  input wire logic [3:0] CH_PRECOND,
  output logic FAULT_DUMP,
  output logic PROTECT,
  output logic CLEAR,
  output logic SYNC_LOAD,
  output logic DEV_RESET,
  output logic [3:0] CURRENT_OUTPUT_PD,
  output logic [3:0] CURRENT_OUTPUT_PU,
  output logic [3:0] VOLTAGE_OUTPUT_PD,
  output logic [3:0] VOLTAGE_OUTPUT_PU,
  output logic [3:0] VOLTAGE_OUTPUT_PD_SEL
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    mfg_pkg::mfg_cfg_t cfg;
    logic cfg_nvm;
    mfg_pkg::mfg_phase_t phase;
    logic boot_wait;
    mfg_pkg::mfg_act_t act;
    logic pin_out;
    logic pin_oe;
    logic [31:0] prdata;
  } mfg_st_t;
  mfg_st_t st, next_st;
  logic lvl, rise, fall;
  mfg_sync u_sync (
    .clk(CLK),
    .rst(SYS_RST),
    .pin(PIN_IN),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic fn_known(input logic [3:0] fn);
    case (fn)
      `MFG_FN_FAULT, `MFG_FN_CURRENT_OUTPUT, `MFG_FN_VOLTAGE_OUTPUT, `MFG_FN_PROTECT,
      `MFG_FN_CLEAR, `MFG_FN_SYNC, `MFG_FN_RESET: fn_known = 1'b1;
      default: fn_known = 1'b0;
    endcase
  endfunction
  // status code to bit of STATUS_IN
  function automatic logic status_sel(input logic [3:0] fn, input logic [10:0] s);
    case (fn)
      4'h1: status_sel = s[0];
      4'h4: status_sel = s[3];
      4'h5: status_sel = s[4];
      4'h6: status_sel = s[5];
      4'h7: status_sel = s[6];
      4'h8: status_sel = s[7];
      4'h9: status_sel = s[8];
      4'ha: status_sel = s[9];
      4'hb: status_sel = s[10];
      default: status_sel = 1'b0;
    endcase
  endfunction

  // channel mask when the edge or level hits
  function automatic logic [3:0] chan_mask(input logic hit, input logic [3:0] ch);
    chan_mask = hit ? ch : 4'h0;
  endfunction

  logic setup, acc, wr, rd;
  logic mapped;
  logic [3:0] sel_ch;
  assign setup = PSEL & ~PENABLE;
  assign acc = PSEL & PENABLE;
  assign wr = acc & PWRITE;
  assign rd = setup & ~PWRITE;
  assign mapped = st.cfg.pin_input_enable & fn_known(st.cfg.in_fn);
  assign sel_ch = st.cfg.trigger_channel_select & CH_PRECOND;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic ef, er, lv_lo, lv_hi;
    logic [3:0] fn;
    mfg_pkg::mfg_act_t a;
    next_st = st;
    a = '0;
    fn = st.cfg.in_fn;
    ef = 1'b0;
    er = 1'b0;
    lv_lo = 1'b0;
    lv_hi = 1'b0;

    // ----------------------------------------
    // boot phases
    // ----------------------------------------
    // first cycle takes nvm, second lets the synchroniser
    // fill with the real pin, then one level sample
    case (st.phase)
      mfg_pkg::MFG_BOOT: begin
        if (!st.boot_wait) begin
          if (NVM_VALID) begin
            next_st.cfg = mfg_pkg::mfg_cfg_t'(NVM_CFG[21:0]);
            next_st.cfg_nvm = 1'b1;
          end
          next_st.boot_wait = 1'b1;
        end else begin
          next_st.phase = mfg_pkg::MFG_LEVEL;
        end
      end
      mfg_pkg::MFG_LEVEL: begin
        lv_lo = ~lvl;
        lv_hi = lvl;
        next_st.phase = mfg_pkg::MFG_RUN;
      end
      mfg_pkg::MFG_RUN: begin
        ef = fall;
        er = rise;
      end
      default: begin
        next_st.phase = mfg_pkg::MFG_BOOT;
      end
    endcase

    // ----------------------------------------
    // pin gate
    // ----------------------------------------
    if (!st.cfg.pin_input_enable) begin
      ef = 1'b0;
      er = 1'b0;
      lv_lo = 1'b0;
      lv_hi = 1'b0;
    end

    // ----------------------------------------
    // pin function decode
    // ----------------------------------------
    case (fn)
      `MFG_FN_FAULT: begin
        a.fault_dump = ef | lv_lo;
      end
      `MFG_FN_PROTECT: begin
        a.protect = ef | lv_lo;
      end
      `MFG_FN_CURRENT_OUTPUT: begin
        a.current_output_pd = chan_mask(ef | lv_lo, sel_ch);
        a.current_output_pu = chan_mask(er | lv_hi, sel_ch);
      end
      `MFG_FN_VOLTAGE_OUTPUT: begin
        a.voltage_output_pd = chan_mask(ef | lv_lo, sel_ch);
        a.voltage_output_pu = chan_mask(er | lv_hi, sel_ch);
      end
      `MFG_FN_CLEAR: begin
        a.output_clear_action = ef | lv_lo;
      end
      `MFG_FN_SYNC: begin
        a.synchronous_load_action = (ef | lv_lo) & |(sel_ch & st.cfg.sync_update);
      end
      `MFG_FN_RESET: begin
        a.dev_reset = er & st.cfg_nvm;
      end
      default: begin
        a = '0;
      end
    endcase

    // ----------------------------------------
    // software triggers
    // ----------------------------------------
    // dropped while the pin owns that function
    if (wr && PADDR == `MFG_OFF_SWCMD) begin
      if (!(mapped && fn == `MFG_FN_FAULT)) begin
        a.fault_dump |= PWDATA[0];
      end
      if (!(mapped && fn == `MFG_FN_PROTECT)) begin
        a.protect |= PWDATA[1];
      end
      if (!(mapped && fn == `MFG_FN_CLEAR)) begin
        a.output_clear_action |= PWDATA[2];
      end
      if (!(mapped && fn == `MFG_FN_SYNC)) begin
        a.synchronous_load_action |= PWDATA[3] & |(CH_PRECOND & st.cfg.sync_update);
      end
    end
    next_st.act = a;

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    if (wr && PADDR == `MFG_OFF_CFG) begin
      next_st.cfg = mfg_pkg::mfg_cfg_t'(PWDATA[21:0]);
      next_st.cfg_nvm = 1'b0;
    end

    // ----------------------------------------
    // output pin
    // ----------------------------------------
    next_st.pin_oe = st.cfg.pin_output_enable & ~st.cfg.pin_input_enable;
    next_st.pin_out = status_sel(st.cfg.out_fn, STATUS_IN);

    // ----------------------------------------
    // read data, captured at setup
    // ----------------------------------------
    if (rd) begin
      case (PADDR)
        `MFG_OFF_CFG: begin
          next_st.prdata = {10'h000, st.cfg};
        end
        `MFG_OFF_STATUS: begin
          next_st.prdata = {28'h0000000, st.phase == mfg_pkg::MFG_RUN,
            st.cfg_nvm, mapped, lvl};
        end
        `MFG_OFF_ACTION: begin
          next_st.prdata = {11'h000, STATUS_IN[9:0], 11'h000};
        end
        `MFG_OFF_NVM: begin
          next_st.prdata = {8'h00, NVM_CFG};
        end
        default: begin
          next_st.prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st.cfg <= mfg_pkg::mfg_cfg_t'(`MFG_CFG_RESET);
      st.cfg_nvm <= 1'b0;
      st.phase <= mfg_pkg::MFG_BOOT;
      st.boot_wait <= 1'b0;
      st.act <= '0;
      st.pin_out <= 1'b0;
      st.pin_oe <= 1'b0;
      st.prdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign PRDATA = st.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = acc & (PADDR[11:5] != 7'h00 || PADDR[1:0] != 2'b00);
  assign PIN_OUT = st.pin_out;
  assign PIN_OE = st.pin_oe;
  assign FAULT_DUMP = st.act.fault_dump;
  assign PROTECT = st.act.protect;
  assign CLEAR = st.act.output_clear_action;
  assign SYNC_LOAD = st.act.synchronous_load_action;
  assign DEV_RESET = st.act.dev_reset;
  assign CURRENT_OUTPUT_PD = st.act.current_output_pd;
  assign CURRENT_OUTPUT_PU = st.act.current_output_pu;
  assign VOLTAGE_OUTPUT_PD = st.act.voltage_output_pd;
  assign VOLTAGE_OUTPUT_PU = st.act.voltage_output_pu;
  assign VOLTAGE_OUTPUT_PD_SEL = st.cfg.voltage_output_pdn_sel;
endmodule
`default_nettype wire

/* File: dv/mfg_asserts.sv */
// Purpose: port checks for mfg_top
// Assumes: one clock, SYS_RST high
// Notes: bound in the bench
`timescale 1ns/1ps
`default_nettype none
module mfg_asserts (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic PIN_OE,
  input wire logic FAULT_DUMP,
  input wire logic CLEAR,
  input wire logic DEV_RESET,
  input wire logic [3:0] CURRENT_OUTPUT_PD,
  input wire logic [3:0] CURRENT_OUTPUT_PU
);
  // ------
  // checks
  // ------
  logic cfg_wr;
  assign cfg_wr = PSEL && PENABLE && PWRITE && PADDR == 12'h000;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_ready_high: assert property (PREADY) else $error("ready low");
  a_err_unmapped: assert property (PSEL && PENABLE && PADDR >= 12'h020 |-> PSLVERR)
    else $error("no error");
  a_fault_pulse: assert property (FAULT_DUMP |=> !FAULT_DUMP)
    else $error("fault long");
  a_clear_pulse: assert property (CLEAR |=> !CLEAR)
    else $error("clear long");
  a_pd_pu_excl: assert property ((CURRENT_OUTPUT_PD & CURRENT_OUTPUT_PU) == 4'h0)
    else $error("down and up");
  a_pu_pulse: assert property (|CURRENT_OUTPUT_PU |=> CURRENT_OUTPUT_PU == 4'h0)
    else $error("up long");
  a_oe_cause: assert property ($changed(PIN_OE) |-> $past(cfg_wr, 2))
    else $error("enable moved");
  a_dev_quiet: assert property ($fell(SYS_RST) |-> !DEV_RESET [*3])
    else $error("early reset");
  cover property (FAULT_DUMP);
  cover property (|CURRENT_OUTPUT_PD);
  cover property (DEV_RESET);
endmodule
`default_nettype wire

/* File: dv/mfg_pin_ext.sv */
// Purpose: controller or strap on the pin
// Assumes: pin pulled high
// Notes: device wins while it drives
`timescale 1ns/1ps
`default_nettype none
module mfg_pin_ext (
  input wire logic clk,
  input wire logic pin_oe,
  input wire logic pin_out,
  output logic pin_level
);
  logic drv_val = 1'b1;
  assign pin_level = pin_oe ? pin_out : drv_val;
  // hold a level for n cycles
  task automatic drive(input logic v, input int n);
    drv_val <= v;
    repeat (n) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: dv/test_multifunction_gpio_trigger.sv */
// Purpose: self-checking bench for mfg_top
// Assumes: APB answers at once
// Notes: action pulses gather into one word
`timescale 1ns/1ps
`default_nettype none
module test_multifunction_gpio_trigger;
  logic CLK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, clr = 1'b0;
  logic PREADY, PSLVERR, PIN_IN, PIN_OUT, PIN_OE, NVM_VALID = 1'b0;
  logic FAULT_DUMP, PROTECT, CLEAR, SYNC_LOAD, DEV_RESET;
  logic [3:0] CH_PRECOND = 4'hf, CURRENT_OUTPUT_PD, CURRENT_OUTPUT_PU, VOLTAGE_OUTPUT_PD, VOLTAGE_OUTPUT_PU, VOLTAGE_OUTPUT_PD_SEL;
  logic [10:0] STATUS_IN = 11'h000;
  logic [11:0] PADDR = 12'h000;
  logic [23:0] NVM_CFG = 24'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA, r;
  logic [20:0] seen;
  logic [77:0] rows [10];
  int miscompares = 0, check_count = 0;
  mfg_top dut (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .NVM_VALID(NVM_VALID),
    .NVM_CFG(NVM_CFG), .STATUS_IN(STATUS_IN), .CH_PRECOND(CH_PRECOND),
    .FAULT_DUMP(FAULT_DUMP), .PROTECT(PROTECT), .CLEAR(CLEAR), .SYNC_LOAD(SYNC_LOAD),
    .DEV_RESET(DEV_RESET), .CURRENT_OUTPUT_PD(CURRENT_OUTPUT_PD), .CURRENT_OUTPUT_PU(CURRENT_OUTPUT_PU), .VOLTAGE_OUTPUT_PD(VOLTAGE_OUTPUT_PD),
    .VOLTAGE_OUTPUT_PU(VOLTAGE_OUTPUT_PU), .VOLTAGE_OUTPUT_PD_SEL(VOLTAGE_OUTPUT_PD_SEL));
  mfg_pin_ext ext (.clk(CLK), .pin_oe(PIN_OE), .pin_out(PIN_OUT), .pin_level(PIN_IN));
  initial forever #2 CLK = ~CLK;
  always @(posedge CLK) seen <= clr ? 21'h0 : seen | {DEV_RESET, FAULT_DUMP, PROTECT, CLEAR,
    SYNC_LOAD, CURRENT_OUTPUT_PD, CURRENT_OUTPUT_PU, VOLTAGE_OUTPUT_PD, VOLTAGE_OUTPUT_PU};
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    r = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic clean();
    clr <= 1'b1;
    @(posedge CLK);
    clr <= 1'b0;
  endtask
  task automatic rst();
    SYS_RST <= 1'b1;
    repeat (5) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
  endtask
  function automatic logic [31:0] c(input logic [3:0] fn, sel, sy);
    return {14'h0, sy, 4'h0, fn, sel, 2'b01};
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge CLK);
    miscompares++;
    give_verdict();
  end
  // ---------
  // stimulus
  // ---------
  initial begin
    rows = '{{c(4'h2, 4'h3, 4'h0), 4'hf, 21'h80000, 21'h0},
      {c(4'h5, 4'h0, 4'h0), 4'hf, 21'h40000, 21'h0},
      {c(4'h3, 4'h5, 4'h0), 4'hf, 21'h05000, 21'h00500},
      {c(4'h4, 4'ha, 4'h0), 4'h6, 21'h00020, 21'h00002},
      {c(4'h7, 4'h0, 4'h0), 4'hf, 21'h20000, 21'h0},
      {c(4'h8, 4'h3, 4'h2), 4'hf, 21'h10000, 21'h0},
      {c(4'h8, 4'h3, 4'h4), 4'hf, 21'h0, 21'h0},
      {c(4'he, 4'hf, 4'h0), 4'hf, 21'h0, 21'h0},
      {c(4'h0, 4'hf, 4'h0), 4'hf, 21'h0, 21'h0},
      {c(4'h2, 4'h3, 4'h0) ^ 32'h1, 4'hf, 21'h0, 21'h0}};
    rst();
    apb(1'b0, 12'h040, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(r, 32'h0);
    foreach (rows[i]) begin
      CH_PRECOND <= rows[i][45:42];
      apb(1'b1, 12'h000, rows[i][77:46]);
      clean();
      ext.drive(1'b0, 8);
      chk(32'(seen), 32'(rows[i][41:21]));
      clean();
      ext.drive(1'b1, 8);
      chk(32'(seen), 32'(rows[i][20:0]));
    end
    apb(1'b1, 12'h000, c(4'h2, 4'h3, 4'h0));
    clean();
    apb(1'b1, 12'h004, 32'h3);
    repeat (3) @(posedge CLK);
    chk(32'(seen), 32'h00040000);
    STATUS_IN <= 11'h008;
    apb(1'b1, 12'h000, 32'h00241002);
    repeat (3) @(posedge CLK);
    chk({30'h0, PIN_OE, PIN_OUT}, 32'h3);
    chk(32'(VOLTAGE_OUTPUT_PD_SEL), 32'h9);
    NVM_CFG <= 24'(c(4'hb, 4'h0, 4'h0));
    NVM_VALID <= 1'b1;
    rst();
    clean();
    ext.drive(1'b0, 8);
    ext.drive(1'b1, 8);
    chk(32'(seen), 32'h00100000);
    apb(1'b1, 12'h000, c(4'hb, 4'h0, 4'h0));
    clean();
    ext.drive(1'b0, 8);
    ext.drive(1'b1, 8);
    chk(32'(seen), 32'h0);
    NVM_CFG <= 24'(c(4'h3, 4'hf, 4'h0));
    ext.drive(1'b0, 1);
    clean();
    rst();
    repeat (8) @(posedge CLK);
    chk(32'(seen[15:8]), 32'hf0);
    give_verdict();
  end
endmodule
bind mfg_top mfg_asserts u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_OE(PIN_OE),
  .FAULT_DUMP(FAULT_DUMP), .CLEAR(CLEAR), .DEV_RESET(DEV_RESET), .CURRENT_OUTPUT_PD(CURRENT_OUTPUT_PD),
  .CURRENT_OUTPUT_PU(CURRENT_OUTPUT_PU));
`default_nettype wire
